// File: bench/rf_front_model.sv
// Attenuator chain and IF converter peak detector model
`timescale 1ns/1ps
module rf_front_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [3:0] level, // Antenna level in steps
  input wire logic [3:0] atten_step,
  input wire logic slow, // Peak only every fourth cycle
  output logic [3:0] peak_amplitude,
  output logic peak_valid
);
  logic [1:0] div_q; // Decimation phase
  logic v; // Sample due this cycle
  assign v = !slow || div_q == 2'h0;
  // Peak after attenuation; garbage between samples
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 2'h0;
      peak_amplitude <= 4'h0;
      peak_valid <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      peak_valid <= v;
      peak_amplitude <= v ? (level > atten_step ? level - atten_step : 4'h0) : ~peak_amplitude;
    end
  end
endmodule : rf_front_model

// File: bench/rx_gain_monitor.sv
// Port checker for the receive gain and timing block
`timescale 1ns/1ps
module rx_gain_monitor
  import rx_gain_timing_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire timing_cfg_t timing_cfg,
  input wire logic timing_cfg_wr,
  input wire logic [3:0] bw_mantissa,
  input wire logic [3:0] bw_exponent,
  input wire logic [7:0] intermediate_freq_analog_word,
  input wire logic freq_cfg_wr,
  input wire logic rx_restart,
  input wire logic [7:0] signal_power,
  input wire logic [STEP_W-1:0] atten_step,
  input wire logic [DB_W-1:0] atten_db,
  input wire logic gain_frozen,
  input wire logic timing_active,
  input wire logic [7:0] channel_bandwidth_word,
  input wire logic [7:0] intermediate_freq_word
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  logic [7:0] thr_q; // Power threshold as the block holds it
  // Shadow of the power threshold latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) thr_q <= PWR_THR_RST;
    else if (timing_cfg_wr) thr_q <= timing_cfg.signal_power_threshold;
  end
  a_step_ceiling: assert property (atten_step <= 4'h8)
    else $error("step above ceiling");
  a_db_scale: assert property (atten_db == atten_step * 6)
    else $error("attenuation not six dB per step");
  a_step_unit: assert property (atten_step != $past(atten_step) |->
    atten_step == $past(atten_step) + 1 || atten_step + 1 == $past(atten_step))
    else $error("step moved by more than one");
  a_frozen_hold: assert property (gain_frozen && $past(gain_frozen) |=> $stable(atten_step))
    else $error("step moved while frozen");
  a_power_start: assert property (!rx_restart && signal_power > thr_q |=> timing_active)
    else $error("timing did not start");
  a_active_keep: assert property (timing_active && !rx_restart |=> timing_active)
    else $error("timing dropped without restart");
  a_restart_clear: assert property (rx_restart && signal_power <= thr_q |=> !timing_active)
    else $error("restart left timing active");
  a_bw_clamp: assert property (freq_cfg_wr |=> channel_bandwidth_word ==
    {$past(bw_mantissa) > BW_MANT_MAX ? BW_MANT_MAX : $past(bw_mantissa),
     $past(bw_exponent) > BW_EXP_MAX ? BW_EXP_MAX : $past(bw_exponent)})
    else $error("bandwidth word wrong");
  a_if_copy: assert property (freq_cfg_wr |=> intermediate_freq_word == $past(intermediate_freq_analog_word))
    else $error("if word wrong");
endmodule : rx_gain_monitor
bind rx_gain_and_timing_recovery rx_gain_monitor mon (.clock, .arst_n, .timing_cfg, .timing_cfg_wr,
  .bw_mantissa, .bw_exponent, .intermediate_freq_analog_word, .freq_cfg_wr, .rx_restart,
  .signal_power, .atten_step, .atten_db, .gain_frozen, .timing_active, .channel_bandwidth_word,
  .intermediate_freq_word);

// File: bench/tb_rx_gain_and_timing_recovery.sv
// Self-checking bench for the receive gain and timing block
`timescale 1ns/1ps
module tb_rx_gain_and_timing_recovery;
  import rx_gain_timing_pkg::*;
  logic clock, arst_n, gc_wr, tc_wr, f_wr, sync_p, rst_p, slow, tv, pv, settled, frozen, act, strb, pfl;
  gain_cfg_t gc;
  timing_cfg_t tc;
  logic [3:0] mant, expo, lvl, pk, step;
  logic [7:0] ifw, pwr, bww, ifo;
  logic [15:0] incr;
  logic signed [11:0] terr;
  logic [5:0] db;
  int mismatches, n_tests, n, e;
  logic [31:0] lfsr_q = 32'h40ecd0a1; // Fixed seed
  rx_gain_and_timing_recovery dut (.clock, .arst_n, .gain_cfg(gc), .gain_cfg_wr(gc_wr), .timing_cfg(tc),
    .timing_cfg_wr(tc_wr), .bw_mantissa(mant), .bw_exponent(expo), .intermediate_freq_analog_word(ifw),
    .freq_cfg_wr(f_wr), .peak_amplitude(pk), .peak_valid(pv), .sync_detected(sync_p), .rx_restart(rst_p),
    .signal_power(pwr), .symbol_rate_incr(incr), .timing_error(terr), .timing_error_valid(tv),
    .atten_step(step), .atten_db(db), .gain_settled(settled), .gain_frozen(frozen), .timing_active(act),
    .symbol_strobe(strb), .postfilter_long(pfl), .channel_bandwidth_word(bww), .intermediate_freq_word(ifo));
  rf_front_model fe (.clock, .arst_n, .level(lvl), .atten_step(step), .slow, .peak_amplitude(pk),
    .peak_valid(pv));
  // Pseudo-random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Gain settings with fixed thresholds; 24-clock measure outlasts the sample gaps
  function automatic gain_cfg_t gcfg(input logic en, frz);
    return '{en, frz, 4'h5, 4'h5, 4'h4, 8'h10, 4'h1, 6'h02};
  endfunction : gcfg
  // Timing settings: order, post-filter, presync integral shift
  function automatic timing_cfg_t tcfg(input logic ord, pf, input logic [3:0] ki);
    return '{ord, pf, 3'h0, 3'h7, ki, 4'hf, 8'h40};
  endfunction : tcfg
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rng(input int v, lo, hi, input string m);
    n_tests++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("CHECK FAILED %0t %s %0d not in %0d..%0d", $time, m, v, lo, hi);
    end
  endtask : rng
  task automatic wr_g(input gain_cfg_t c);
    @(posedge clock);
    gc <= c;
    gc_wr <= 1'b1;
    @(posedge clock);
    gc_wr <= 1'b0;
  endtask : wr_g
  task automatic wr_t(input timing_cfg_t c);
    @(posedge clock);
    tc <= c;
    tc_wr <= 1'b1;
    @(posedge clock);
    tc_wr <= 1'b0;
  endtask : wr_t
  task automatic pulse_sync(input logic r);
    @(posedge clock);
    sync_p <= !r;
    rst_p <= r;
    @(posedge clock);
    sync_p <= 1'b0;
    rst_p <= 1'b0;
  endtask : pulse_sync
  // Waits for a step, then confirms it stays
  task automatic settle(input logic [3:0] want);
    for (int i = 0; i < 3000 && step !== want; i++) @(posedge clock);
    repeat (120) @(posedge clock);
    chk(step, want, "settled step");
    chk(db, want * 6, "settled dB");
  endtask : settle
  // Cycles until the step next moves
  task automatic gap(output int k);
    logic [3:0] s;
    s = step;
    for (k = 0; k < 3000 && step === s; k++) @(posedge clock);
  endtask : gap
  // Counts strobes over 128 cycles, sampled mid-cycle, ends on a rising edge
  task automatic strobes(output int k);
    k = 0;
    repeat (128) begin
      @(negedge clock);
      if (strb === 1'b1) k++;
    end
    @(posedge clock);
  endtask : strobes
  task automatic summarize;
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    summarize();
  end
  // Main sequence
  initial begin
    {arst_n, gc_wr, tc_wr, f_wr, sync_p, rst_p, slow, tv} = '0;
    gc = '0;
    tc = '0;
    {mant, expo, lvl, ifw, pwr, incr, terr} = '0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    // Channel word clamping and IF pass-through
    for (int m = 0; m < 16; m++) begin
      lfsr_q = lfsr(lfsr_q);
      @(posedge clock);
      mant <= 4'(m);
      expo <= lfsr_q[3:0];
      ifw <= lfsr_q[11:4];
      f_wr <= 1'b1;
      @(posedge clock);
      f_wr <= 1'b0;
      @(negedge clock);
      chk(bww, {m > 8 ? 4'h8 : 4'(m), lfsr_q[3:0] > 9 ? 4'h9 : lfsr_q[3:0]}, "bw word");
      chk(ifo, lfsr_q[11:4], "if word");
    end
    wr_t(tcfg(1'b0, 1'b1, 4'h0));
    repeat (3) @(posedge clock);
    chk(pfl, 1'b1, "post-filter");
    $display("done: config words");
    // Random levels: climb to level minus five, fall back to zero
    wr_g(gcfg(1'b1, 1'b0));
    repeat (3) begin
      lfsr_q = lfsr(lfsr_q);
      @(posedge clock);
      slow <= lfsr_q[8];
      lvl <= 4'h6 + lfsr_q[2:0];
      settle(4'h1 + lfsr_q[2:0]);
      chk(settled, 1'b1, "in window");
      lvl <= 4'h0;
      settle(4'h0);
      chk(settled, 1'b0, "below floor");
    end
    $display("done: gain levels");
    // Step spacing, ceiling, per-step floor
    slow <= 1'b0;
    lvl <= 4'hf;
    gap(n);
    gap(n);
    rng(n, 24, 28, "up spacing");
    settle(4'h8);
    lvl <= 4'h8;
    gap(n);
    gap(n);
    rng(n, 48, 54, "down spacing");
    settle(4'h4);
    $display("done: gain timing");
    // Disable, then freeze on sync, then restart
    wr_g(gcfg(1'b0, 1'b0));
    lvl <= 4'hf;
    repeat (200) @(posedge clock);
    chk(step, 4'h4, "disabled");
    pulse_sync(1'b0);
    wr_g(gcfg(1'b1, 1'b1));
    repeat (200) @(posedge clock);
    chk(frozen, 1'b1, "frozen flag");
    chk(step, 4'h4, "frozen step");
    pulse_sync(1'b1);
    settle(4'h8);
    $display("done: enable and freeze");
    // Timing loop start threshold
    pwr <= 8'h40;
    repeat (10) @(posedge clock);
    chk(act, 1'b0, "power at threshold");
    pwr <= 8'h41;
    repeat (3) @(posedge clock);
    chk(act, 1'b1, "power above");
    // Random nominal rate, no error
    lfsr_q = lfsr(lfsr_q);
    incr <= {4'h0, lfsr_q[11:0]} | 16'h0400;
    @(posedge clock);
    strobes(n);
    e = 128 * int'(incr) / 65536;
    rng(n, e - 1, e + 1, "nominal strobes");
    // Proportional gains: fast before sync, slow after
    incr <= 16'h0800;
    terr <= 12'sh7ff;
    tv <= 1'b1;
    pulse_sync(1'b1);
    strobes(n);
    rng(n, 7, 9, "presync strobes");
    pulse_sync(1'b0);
    strobes(n);
    rng(n, 3, 5, "postsync strobes");
    // Second order loop pulls frequency
    wr_t(tcfg(1'b1, 1'b0, 4'h4));
    pulse_sync(1'b1);
    strobes(n);
    rng(n, 20, 27, "second order strobes");
    chk(pfl, 1'b0, "post-filter off");
    pwr <= 8'h00;
    pulse_sync(1'b1);
    @(negedge clock);
    chk(act, 1'b0, "restart");
    $display("done: timing loop");
    summarize();
  end
endmodule : tb_rx_gain_and_timing_recovery

// File: src/interval_timer.sv
// Down-counting interval timer with one-cycle done pulse
`timescale 1ns/1ps
module interval_timer #(
  parameter int W = 20
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire logic [W-1:0] count,
  output logic done,
  output logic busy
);
  logic [W-1:0] cnt_q; // Remaining cycles
  logic run_q;         // Counting

  // Load on start, count down, pulse done at the last cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      run_q <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // A zero count finishes on the next edge
        cnt_q <= (count == '0) ? '0 : count - 1'b1;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == '0) begin
          run_q <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign busy = run_q;
endmodule : interval_timer

// File: src/rx_gain_and_timing_recovery.sv
// Receive gain control loop and symbol timing recovery loop
`timescale 1ns/1ps
module rx_gain_and_timing_recovery #(
  parameter int AMP_W = 4,
  parameter int ERR_W = 12
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire rx_gain_timing_pkg::gain_cfg_t gain_cfg,
  input wire logic gain_cfg_wr,
  input wire rx_gain_timing_pkg::timing_cfg_t timing_cfg,
  input wire logic timing_cfg_wr,
  input wire logic [3:0] bw_mantissa,
  input wire logic [3:0] bw_exponent,
  input wire logic [7:0] intermediate_freq_analog_word,
  input wire logic freq_cfg_wr,
  input wire logic [AMP_W-1:0] peak_amplitude,
  input wire logic peak_valid,
  input wire logic sync_detected,
  input wire logic rx_restart,
  input wire logic [7:0] signal_power,
  input wire logic [rx_gain_timing_pkg::PHASE_W-1:0] symbol_rate_incr,
  input wire logic signed [ERR_W-1:0] timing_error,
  input wire logic timing_error_valid,
  output logic [rx_gain_timing_pkg::STEP_W-1:0] atten_step,
  output logic [rx_gain_timing_pkg::DB_W-1:0] atten_db,
  output logic gain_settled,
  output logic gain_frozen,
  output logic timing_active,
  output logic symbol_strobe,
  output logic postfilter_long,
  output logic [7:0] channel_bandwidth_word,
  output logic [7:0] intermediate_freq_word
);
  import rx_gain_timing_pkg::*;

  localparam int SUM_W = PHASE_W + 3; // Room for carry and sign

  gain_cfg_t gcfg_q;              // Latched gain settings
  timing_cfg_t tcfg_q;            // Latched timing settings
  gain_state_t state_q;           // Gain loop state
  logic [STEP_W-1:0] step_q;      // Attenuation step index
  logic sync_seen_q;              // Sync word received this frame
  logic below_q;                  // All samples so far below low
  logic between_q;                // Last sample inside the window
  logic hold_start;               // Kick hold timer
  logic meas_start;               // Kick measure timer
  logic hold_done;
  logic meas_done;
  logic [TMR_W-1:0] hold_cnt;     // Hold interval in clocks
  logic [TMR_W-1:0] meas_cnt;     // Measure interval in clocks
  logic [3:0] low_thr;            // Floor for the current step
  logic over_high;                // Sample above ceiling
  logic under_low;                // Sample below floor
  logic run;                      // Loop allowed to act
  logic signed [SUM_W-1:0] integ_q; // Second order frequency term
  logic [PHASE_W-1:0] phase_q;    // Bit-timing accumulator
  logic signed [SUM_W-1:0] err_ext;
  logic signed [SUM_W-1:0] prop_corr;
  logic signed [SUM_W-1:0] integ_corr;
  logic signed [SUM_W-1:0] phase_sum;
  logic [2:0] kp;                 // Active proportional shift
  logic [3:0] ki;                 // Active integral shift

  // Settings latch, loaded by write strobes, reset to advised values
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gcfg_q <= '{enable: 1'b0, freeze_on_sync: 1'b0, high_thr: HIGH_THR_RST,
                  low_thr0: LOW_THR0_RST, low_thr1: LOW_THR1_RST,
                  low_sel: LOW_SEL_RST, meas_exp: MEAS_EXP_RST,
                  hold_count: HOLD_CNT_RST};
    end else if (gain_cfg_wr) begin
      gcfg_q <= gain_cfg;
    end
  end

  // Timing settings latch
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tcfg_q <= '{loop_order: 1'b0, postfilter_long: 1'b0,
                  prop_gain_presync: PGAIN_FAST_RST, prop_gain_postsync: PGAIN_SLOW_RST,
                  integ_gain_presync: IGAIN_FAST_RST, integ_gain_postsync: IGAIN_SLOW_RST,
                  signal_power_threshold: PWR_THR_RST};
    end else if (timing_cfg_wr) begin
      tcfg_q <= timing_cfg;
    end
  end

  // Sync seen flag; a sync in the restart cycle still counts
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync_seen_q <= 1'b0;
    end else if (sync_detected) begin
      sync_seen_q <= 1'b1;
    end else if (rx_restart) begin
      sync_seen_q <= 1'b0;
    end
  end

  // Interval lengths in clocks
  always_comb begin
    hold_cnt = TMR_W'(TICK_CLKS) * TMR_W'(gcfg_q.hold_count);
    meas_cnt = TMR_W'(TICK_CLKS) << gcfg_q.meas_exp;
  end

  // Comparisons against ceiling and per-step floor
  always_comb begin
    // Step eight has no bit of its own and reuses the top one
    if (step_q >= STEP_W'(MAX_STEP)) begin
      low_thr = gcfg_q.low_sel[7] ? gcfg_q.low_thr1 : gcfg_q.low_thr0;
    end else begin
      low_thr = gcfg_q.low_sel[step_q[2:0]] ? gcfg_q.low_thr1 : gcfg_q.low_thr0;
    end
    over_high = peak_valid && (peak_amplitude > AMP_W'(gcfg_q.high_thr));
    under_low = peak_amplitude < AMP_W'(low_thr);
    run = gcfg_q.enable && !(gcfg_q.freeze_on_sync && sync_seen_q);
  end

  interval_timer #(.W(TMR_W)) u_hold_timer (
    .clock(clock),
    .arst_n(arst_n),
    .start(hold_start),
    .count(hold_cnt),
    .done(hold_done),
    .busy()
  );

  interval_timer #(.W(TMR_W)) u_meas_timer (
    .clock(clock),
    .arst_n(arst_n),
    .start(meas_start),
    .count(meas_cnt),
    .done(meas_done),
    .busy()
  );

  // Timer kicks follow the state transitions below
  always_comb begin
    hold_start = 1'b0;
    meas_start = 1'b0;
    case (state_q)
      GAIN_IDLE: begin
        meas_start = run;
      end
      GAIN_HOLD: begin
        // Measuring resumes once the level has settled
        meas_start = run && hold_done;
      end
      GAIN_MEAS: begin
        if (!run) begin
          hold_start = 1'b0;
        end else if (over_high && step_q < STEP_W'(MAX_STEP)) begin
          hold_start = 1'b1;
        end else if (meas_done && below_q && step_q != '0) begin
          hold_start = 1'b1;
        end else if (meas_done) begin
          meas_start = 1'b1;
        end
      end
      default: begin
        hold_start = 1'b0;
      end
    endcase
  end

  // Gain loop state and attenuation step
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= GAIN_IDLE;
      step_q <= '0;
    end else begin
      case (state_q)
        GAIN_IDLE: begin
          if (run) begin
            state_q <= GAIN_MEAS;
          end
        end
        GAIN_HOLD: begin
          // Hold runs out even if the loop is frozen meanwhile
          if (hold_done) begin
            state_q <= run ? GAIN_MEAS : GAIN_IDLE;
          end
        end
        GAIN_MEAS: begin
          if (!run) begin
            state_q <= GAIN_IDLE;
          end else if (over_high && step_q < STEP_W'(MAX_STEP)) begin
            // Measure time forced to zero on the way up
            step_q <= step_q + 1'b1;
            state_q <= GAIN_HOLD;
          end else if (meas_done && below_q && step_q != '0) begin
            step_q <= step_q - 1'b1;
            state_q <= GAIN_HOLD;
          end
        end
        default: begin
          state_q <= GAIN_IDLE;
        end
      endcase
    end
  end

  // Below-floor tracking across the whole measure interval
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      below_q <= 1'b1;
    end else if (meas_start) begin
      below_q <= 1'b1;
    end else if (peak_valid && !under_low) begin
      below_q <= 1'b0;
    end
  end

  // Window status of the latest sample
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      between_q <= 1'b0;
    end else if (peak_valid) begin
      between_q <= !over_high && !under_low;
    end
  end

  // Gain outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      atten_step <= '0;
      atten_db <= '0;
      gain_settled <= 1'b0;
      gain_frozen <= 1'b0;
    end else begin
      atten_step <= step_q;
      atten_db <= DB_W'(step_q * STEP_DB);
      gain_settled <= between_q && state_q == GAIN_MEAS;
      gain_frozen <= gcfg_q.enable && gcfg_q.freeze_on_sync && sync_seen_q;
    end
  end

  // Gain set chosen by sync state
  always_comb begin
    kp = sync_seen_q ? tcfg_q.prop_gain_postsync : tcfg_q.prop_gain_presync;
    ki = sync_seen_q ? tcfg_q.integ_gain_postsync : tcfg_q.integ_gain_presync;
    err_ext = timing_error_valid ? SUM_W'(timing_error) : '0;
    // Shift grows with the gain value, so small values move faster
    prop_corr = err_ext >>> kp;
    integ_corr = err_ext >>> ki;
    phase_sum = $signed({3'b000, phase_q}) + $signed({3'b000, symbol_rate_incr}) + prop_corr;
    if (tcfg_q.loop_order) begin
      phase_sum = phase_sum + integ_q;
    end
  end

  // Start timing recovery only with enough signal power
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      timing_active <= 1'b0;
    end else if (rx_restart) begin
      timing_active <= 1'b0;
    end else if (signal_power > tcfg_q.signal_power_threshold) begin
      timing_active <= 1'b1;
    end
  end

  // Second order integrator, cleared in first order mode
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      integ_q <= '0;
    end else if (!timing_active || !tcfg_q.loop_order) begin
      integ_q <= '0;
    end else if (timing_error_valid) begin
      integ_q <= integ_q + integ_corr;
    end
  end

  // Bit-timing accumulator; a wrap marks a symbol instant
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= '0;
      symbol_strobe <= 1'b0;
    end else if (!timing_active) begin
      phase_q <= '0;
      symbol_strobe <= 1'b0;
    end else begin
      phase_q <= phase_sum[PHASE_W-1:0];
      // Negative sums only pull the phase back, no strobe
      symbol_strobe <= !phase_sum[SUM_W-1] && (phase_sum[SUM_W-2:PHASE_W] != '0);
    end
  end

  // Channel filter word clamped to legal codes, IF word passed through as written
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      channel_bandwidth_word <= '0;
      intermediate_freq_word <= IF_WORD_RST;
    end else if (freq_cfg_wr) begin
      channel_bandwidth_word[7:4] <= (bw_mantissa > BW_MANT_MAX) ? BW_MANT_MAX : bw_mantissa;
      channel_bandwidth_word[3:0] <= (bw_exponent > BW_EXP_MAX) ? BW_EXP_MAX : bw_exponent;
      intermediate_freq_word <= intermediate_freq_analog_word;
    end
  end

  // Post-filter length to the demodulator
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      postfilter_long <= 1'b0;
    end else begin
      postfilter_long <= tcfg_q.postfilter_long;
    end
  end
endmodule : rx_gain_and_timing_recovery

// File: src/rx_gain_timing_pkg.sv
// Shared constants and carrier types for the receive gain and timing block
package rx_gain_timing_pkg;
  // Attenuation stepping
  localparam int STEP_DB = 6;          // dB per attenuation step
  localparam int MAX_ATTEN_DB = 48;    // Ceiling on total attenuation
  localparam int MAX_STEP = MAX_ATTEN_DB / STEP_DB; // Highest step index
  localparam int STEP_W = 4;           // Step index width
  localparam int DB_W = 6;             // Attenuation in dB width
  // Timer base: both gain intervals are multiples of twelve clocks
  localparam int TICK_CLKS = 12;
  localparam int TMR_W = 20;           // Enough for 12 * 2^15
  localparam int MEAS_EXP_MAX = 15;    // Largest measure exponent
  // Gain loop reset values
  localparam logic [3:0] HIGH_THR_RST = 4'h5;
  localparam logic [3:0] LOW_THR0_RST = 4'h5;
  localparam logic [3:0] LOW_THR1_RST = 4'h4;
  localparam logic [7:0] LOW_SEL_RST = 8'h10;
  localparam logic [3:0] MEAS_EXP_RST = 4'h2;
  localparam logic [5:0] HOLD_CNT_RST = 6'h0c;
  // Timing loop reset values
  localparam logic [2:0] PGAIN_FAST_RST = 3'h1;
  localparam logic [2:0] PGAIN_SLOW_RST = 3'h2;
  localparam logic [3:0] IGAIN_FAST_RST = 4'h8;
  localparam logic [3:0] IGAIN_SLOW_RST = 4'ha;
  localparam logic [7:0] PWR_THR_RST = 8'h00;
  // Channel filter word limits
  localparam logic [3:0] BW_MANT_MAX = 4'h8;
  localparam logic [3:0] BW_EXP_MAX = 4'h9;
  // Intermediate frequency offset word reset
  localparam logic [7:0] IF_WORD_RST = 8'h00;
  localparam int PHASE_W = 16;         // Bit-timing accumulator width

  // Gain loop state
  typedef enum logic [1:0] {
    GAIN_IDLE = 2'b00,
    GAIN_HOLD = 2'b01,
    GAIN_MEAS = 2'b10
  } gain_state_t;

  // Gain loop settings (ceiling, floors, selection, timers)
  typedef struct packed {
    logic enable;
    logic freeze_on_sync;
    logic [3:0] high_thr;
    logic [3:0] low_thr0;
    logic [3:0] low_thr1;
    logic [7:0] low_sel;
    logic [3:0] meas_exp;
    logic [5:0] hold_count;
  } gain_cfg_t;

  // Timing loop settings
  typedef struct packed {
    logic loop_order;                  // 0 first order, 1 second order
    logic postfilter_long;
    logic [2:0] prop_gain_presync;
    logic [2:0] prop_gain_postsync;
    logic [3:0] integ_gain_presync;
    logic [3:0] integ_gain_postsync;
    logic [7:0] signal_power_threshold;
  } timing_cfg_t;
endpackage : rx_gain_timing_pkg
